/* File: apsf_pkg.sv */
package apsf_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [9:0] IDX_SOURCE_SELECT = 10'h102;
	localparam logic [9:0] IDX_PHASE_STEP    = 10'h103;
	localparam logic [9:0] IDX_FB_DIVIDE0    = 10'h106;
	localparam int         FB_DIVIDE_BYTES   = 6;
	localparam logic [9:0] IDX_SYS_CONTROL   = 10'h120;
	localparam logic [9:0] IDX_ROUTE_STATUS  = 10'h121;
	localparam logic [9:0] IDX_STEP_COUNT    = 10'h122;
	localparam int         ADR_W             = 12;

	// source select register fields
	localparam int POS_EXT_SWITCH = 6;
	localparam int POS_ALT_LO     = 3;
	localparam int POS_PRI_LO     = 0;

	// phase step register fields
	localparam int POS_DOWN_BIT = 7;
	localparam int POS_DOWN_SRC = 4;
	localparam int POS_UP_BIT   = 3;
	localparam int POS_UP_SRC   = 0;

	// system control register fields
	localparam int POS_BYPASS     = 0;
	localparam int POS_DOUBLER    = 1;
	localparam int POS_MC_IC1     = 2;
	localparam int POS_SW_PIN_LO  = 4;

	// divide word layout
	localparam int FB_W      = 42;
	localparam int FB_INT_W  = 9;
	localparam int FB_FRAC_W = 33;
	localparam int FB_TOP_W  = 2;

	localparam logic [7:0]      RST_BYTE = 8'h00;
	localparam logic [FB_W-1:0] RST_FB   = 42'h000_0000_0000;

	typedef enum logic [2:0] {
		SRC_NONE  = 3'b000,
		SRC_XTAL  = 3'b001,
		SRC_IC1   = 3'b010,
		SRC_IC2   = 3'b011,
		SRC_IC3   = 3'b100,
		SRC_DPLL  = 3'b101
	} apsf_src_t;

	typedef struct packed {
		apsf_src_t apllSrc;
		apsf_src_t bypassSrc;
		logic      bypassSel;
		logic      xtalDoubled;
		logic      xtalPinDirect;
		logic      dpllPowerDownOk;
		logic      altInUse;
	} apsf_route_t;

	typedef struct packed {
		logic [FB_INT_W-1:0]  intPart;
		logic [FB_FRAC_W-1:0] fracPart;
	} apsf_fb_t;

endpackage

/* File: apsf_config.sv */
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - switch mode: pin low primary, high alternate
// - alternate field ignored unless switching enabled
// - alternate codes: crystal, input clocks one-three
// - primary 001-011 route input clock to both
// - 110 dpll plus crystal bypass; 111 no bypass
// - 100/101 master clock from input one variants
// - primary 0xx direct pin, dpll may power down
// - alternate drives pll; primary keeps bypass source
// - doubler doubles crystal frequency when crystal selected
// - down source: register bit or pins zero-three
// - phase down on every edge of source
// - down source 000 uses register down bit
// - down moves edges earlier, up later
// - up source: register bit or pins, both edges
// - up source 000 uses register up bit
// - 42-bit divide word, six bytes, lsb first
// - unsigned: nine integer, 33 fraction bits
// - bypass bit picks divider output or bypass
module apsf_config (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [apsf_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [3:0]                  gpPin,
	input  wire logic                        crystalPresent,
	output apsf_pkg::apsf_route_t            route,
	output apsf_pkg::apsf_fb_t               fbDivideValue,
	output logic                             phaseUpStep,
	output logic                             phaseDownStep
);

	// reset release
	logic [1:0]  rstPipe_q;
	logic        rstSync_n;

	// software visible registers
	logic [7:0]  srcSel_q;
	logic [7:0]  phaseCtl_q;
	logic [7:0]  sysCtl_q;
	logic [apsf_pkg::FB_W-1:0] fb_q;

	// pin synchroniser and step detection
	logic [3:0]  pinMeta_q;
	logic [3:0]  pin_q;
	logic        upPrev_q;
	logic        downPrev_q;
	logic [2:0]  upSrcPrev_q;
	logic [2:0]  downSrcPrev_q;
	logic [7:0]  stepCount_q;
	logic        upNow;
	logic        downNow;
	logic        upEdge;
	logic        downEdge;

	// routing
	apsf_pkg::apsf_route_t route_d;
	logic        switchPin;
	logic        useAlt;

	// bus decode
	logic        wbReq;
	logic        wbWrite;
	logic        wbRead;
	logic [9:0]  idx;
	logic [31:0] rdData;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_q <= 2'b00;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstSync_n = rstPipe_q[1];

	// pin inputs are asynchronous in practice; two flops, edges only on pin_q
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pinMeta_q <= 4'h0;
		end else begin
			pinMeta_q <= gpPin;
		end
	end

	// only this second stage is read by the rest of the block
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pin_q <= 4'h0;
		end else begin
			pin_q <= pinMeta_q;
		end
	end

	// step source: code 0 register bit, codes 1-4 pins 0-3, rest idle low
	function automatic logic stepSource(input logic [2:0] code, input logic regBit, input logic [3:0] pins);
		unique case (code)
			3'b000:  stepSource = regBit;
			3'b001:  stepSource = pins[0];
			3'b010:  stepSource = pins[1];
			3'b011:  stepSource = pins[2];
			3'b100:  stepSource = pins[3];
			default: stepSource = 1'b0;
		endcase
	endfunction

	// direct input codes shared by the primary and alternate fields
	function automatic apsf_pkg::apsf_src_t directSource(input logic [2:0] code);
		unique case (code)
			3'b000:  directSource = apsf_pkg::SRC_XTAL;
			3'b001:  directSource = apsf_pkg::SRC_IC1;
			3'b010:  directSource = apsf_pkg::SRC_IC2;
			3'b011:  directSource = apsf_pkg::SRC_IC3;
			default: directSource = apsf_pkg::SRC_NONE;
		endcase
	endfunction

	assign switchPin = pin_q[sysCtl_q[apsf_pkg::POS_SW_PIN_LO +: 2]];
	assign useAlt    = srcSel_q[apsf_pkg::POS_EXT_SWITCH] & switchPin;

	always_comb begin
		logic [2:0] pri;
		logic [2:0] alt;
		pri = srcSel_q[apsf_pkg::POS_PRI_LO +: 3];
		alt = srcSel_q[apsf_pkg::POS_ALT_LO +: 3];
		route_d = '0;
		route_d.bypassSel = sysCtl_q[apsf_pkg::POS_BYPASS];
		route_d.altInUse  = useAlt;
		// bypass source always follows the primary field
		unique case (pri)
			3'b000, 3'b001, 3'b010, 3'b011: begin
				route_d.apllSrc         = directSource(pri);
				route_d.bypassSrc       = directSource(pri);
				route_d.dpllPowerDownOk = 1'b1;
			end
			3'b110: begin
				route_d.apllSrc   = apsf_pkg::SRC_DPLL;
				route_d.bypassSrc = apsf_pkg::SRC_XTAL;
			end
			3'b100: begin
				route_d.apllSrc   = apsf_pkg::SRC_DPLL;
				// only meaningful with the master clock on input one
				route_d.bypassSrc = sysCtl_q[apsf_pkg::POS_MC_IC1] ? apsf_pkg::SRC_IC1 : apsf_pkg::SRC_NONE;
			end
			// no bypass signal: software must keep the bypass bit clear here
			3'b101: begin
				route_d.apllSrc   = apsf_pkg::SRC_DPLL;
				route_d.bypassSrc = apsf_pkg::SRC_NONE;
			end
			3'b111: begin
				route_d.apllSrc   = apsf_pkg::SRC_DPLL;
				route_d.bypassSrc = apsf_pkg::SRC_NONE;
			end
		endcase
		if (useAlt) begin
			route_d.apllSrc         = directSource(alt);
			route_d.dpllPowerDownOk = (alt[2] == 1'b0);
		end
		// doubler acts wherever the crystal path is used
		route_d.xtalDoubled   = sysCtl_q[apsf_pkg::POS_DOUBLER] &
			(route_d.apllSrc == apsf_pkg::SRC_XTAL || route_d.bypassSrc == apsf_pkg::SRC_XTAL);
		route_d.xtalPinDirect = ~crystalPresent;
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			route <= '0;
		end else begin
			route <= route_d;
		end
	end

	// phase stepping: both edges of the chosen signal count
	assign upNow    = stepSource(phaseCtl_q[apsf_pkg::POS_UP_SRC +: 3],
		phaseCtl_q[apsf_pkg::POS_UP_BIT], pin_q);
	assign downNow  = stepSource(phaseCtl_q[apsf_pkg::POS_DOWN_SRC +: 3],
		phaseCtl_q[apsf_pkg::POS_DOWN_BIT], pin_q);
	// a source change re-arms the detector instead of faking a step
	assign upEdge   = (upNow ^ upPrev_q) & (upSrcPrev_q == phaseCtl_q[apsf_pkg::POS_UP_SRC +: 3]);
	assign downEdge = (downNow ^ downPrev_q)
		& (downSrcPrev_q == phaseCtl_q[apsf_pkg::POS_DOWN_SRC +: 3]);

	// idle level after reset is low, matching the idle pins and register bits
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			upPrev_q    <= 1'b0;
			upSrcPrev_q <= 3'b000;
		end else begin
			upPrev_q    <= upNow;
			upSrcPrev_q <= phaseCtl_q[apsf_pkg::POS_UP_SRC +: 3];
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			downPrev_q    <= 1'b0;
			downSrcPrev_q <= 3'b000;
		end else begin
			downPrev_q    <= downNow;
			downSrcPrev_q <= phaseCtl_q[apsf_pkg::POS_DOWN_SRC +: 3];
		end
	end

	// one registered pulse per detected edge
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			phaseUpStep <= 1'b0;
		end else begin
			phaseUpStep <= upEdge;
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			phaseDownStep <= 1'b0;
		end else begin
			phaseDownStep <= downEdge;
		end
	end

	// net phase position: down is earlier (negative), up is later
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			stepCount_q <= 8'h00;
		end else if (upEdge && !downEdge) begin
			stepCount_q <= stepCount_q + 8'h01;
		end else if (downEdge && !upEdge) begin
			stepCount_q <= stepCount_q - 8'h01;
		end
	end

	// wishbone classic slave: ack one cycle after the strobe, write at the ack edge
	assign idx     = wb_adr_i[apsf_pkg::ADR_W-1:2];
	assign wbReq   = wb_cyc_i & wb_stb_i;
	assign wbWrite = wbReq & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign wbRead  = wbReq & ~wb_ack_o;

	// one index compare, shared by the write and read decoders
	function automatic logic isFbByte(input logic [9:0] ix, input int k);
		isFbByte = (ix == apsf_pkg::IDX_FB_DIVIDE0 + 10'(k));
	endfunction

	// fixed one-cycle answer; the master must drop the strobe before the next access
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wbReq & ~wb_ack_o;
		end
	end

	// bit 7 has no storage and reads back as zero
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			srcSel_q <= apsf_pkg::RST_BYTE;
		end else if (wbWrite && idx == apsf_pkg::IDX_SOURCE_SELECT) begin
			srcSel_q <= {1'b0, wb_dat_i[6:0]};
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			phaseCtl_q <= apsf_pkg::RST_BYTE;
		end else if (wbWrite && idx == apsf_pkg::IDX_PHASE_STEP) begin
			phaseCtl_q <= wb_dat_i[7:0];
		end
	end

	// unused bits are not stored, so they cannot leak into the pin select
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			sysCtl_q <= apsf_pkg::RST_BYTE;
		end else if (wbWrite && idx == apsf_pkg::IDX_SYS_CONTROL) begin
			sysCtl_q <= {2'b00, wb_dat_i[5:4], 1'b0, wb_dat_i[2:0]};
		end
	end

	// divide word: byte k at index base+k, least significant first
	// no shadowing: each byte takes effect alone, so software sees a mixed word mid-update
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			fb_q <= apsf_pkg::RST_FB;
		end else if (wbWrite) begin
			for (int k = 0; k < apsf_pkg::FB_DIVIDE_BYTES - 1; k++) begin
				if (isFbByte(idx, k)) begin
					fb_q[8*k +: 8] <= wb_dat_i[7:0];
				end
			end
			// upper six bits of the last byte have no storage
			if (isFbByte(idx, apsf_pkg::FB_DIVIDE_BYTES - 1)) begin
				fb_q[apsf_pkg::FB_W-1 -: apsf_pkg::FB_TOP_W] <= wb_dat_i[1:0];
			end
		end
	end

	// value stays as written; zero and bad top bits are software's burden
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			fbDivideValue <= '0;
		end else begin
			fbDivideValue <= apsf_pkg::apsf_fb_t'(fb_q);
		end
	end

	// unmapped indices read zero; only the status word is wider than a byte
	always_comb begin
		rdData = 32'h0000_0000;
		unique case (idx)
			apsf_pkg::IDX_SOURCE_SELECT: rdData[7:0] = srcSel_q;
			apsf_pkg::IDX_PHASE_STEP:    rdData[7:0] = phaseCtl_q;
			apsf_pkg::IDX_SYS_CONTROL:   rdData[7:0] = sysCtl_q;
			apsf_pkg::IDX_ROUTE_STATUS:  rdData[10:0] = route;
			apsf_pkg::IDX_STEP_COUNT:    rdData[7:0] = stepCount_q;
			default: begin
				for (int k = 0; k < apsf_pkg::FB_DIVIDE_BYTES - 1; k++) begin
					if (isFbByte(idx, k)) begin
						rdData[7:0] = fb_q[8*k +: 8];
					end
				end
				// last byte kept apart so no slice runs past bit 41
				if (isFbByte(idx, apsf_pkg::FB_DIVIDE_BYTES - 1)) begin
					rdData[7:0] = {6'h00, fb_q[apsf_pkg::FB_W-1 -: apsf_pkg::FB_TOP_W]};
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wbRead) begin
			wb_dat_o <= rdData;
		end
	end

endmodule

`default_nettype wire

/* File: apsf_config_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module apsf_config_checker (
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [11:0]           wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic [3:0]            gpPin,
	input wire logic                  crystalPresent,
	input wire apsf_pkg::apsf_route_t route,
	input wire apsf_pkg::apsf_fb_t    fbDivideValue,
	input wire logic                  phaseUpStep,
	input wire logic                  phaseDownStep
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer late or long");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:2] > 10'h122 |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	top_bits_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[11:2] == 10'h10B
		|-> ##2 fbDivideValue[41:40] == $past(wb_dat_i[1:0], 2))
		else $error("sixth byte not in top bits");
	pwr_down_a: assert property (!route.altInUse && route.apllSrc != apsf_pkg::SRC_NONE
		|-> route.dpllPowerDownOk == (route.apllSrc != apsf_pkg::SRC_DPLL))
		else $error("power down hint wrong");
	alt_src_a: assert property (route.altInUse |-> route.apllSrc != apsf_pkg::SRC_DPLL)
		else $error("alternate picked digital loop");
	ic_both_a: assert property (!route.altInUse && route.apllSrc inside {apsf_pkg::SRC_IC1, apsf_pkg::SRC_IC2,
		apsf_pkg::SRC_IC3} |-> route.bypassSrc == route.apllSrc)
		else $error("input clock not on both paths");
	dbl_xtal_a: assert property (route.xtalDoubled
		|-> route.apllSrc == apsf_pkg::SRC_XTAL || route.bypassSrc == apsf_pkg::SRC_XTAL)
		else $error("doubled without crystal");
	xtal_pin_a: assert property ($stable(crystalPresent) [*4] |-> route.xtalPinDirect == !crystalPresent)
		else $error("crystal pin flag wrong");
endmodule
bind apsf_config apsf_config_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gpPin(gpPin), .crystalPresent(crystalPresent), .route(route),
	.fbDivideValue(fbDivideValue), .phaseUpStep(phaseUpStep), .phaseDownStep(phaseDownStep));
`default_nettype wire

/* File: test_apsf_config.sv */
`timescale 1ns/1ps
`default_nettype none
module test_apsf_config;
	logic                  clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, xp = 1;
	logic [11:0]           adr = 0;
	logic [3:0]            gp = 0;
	logic [31:0]           dat = 0, rdat;
	logic                  ack, up, dn;
	apsf_pkg::apsf_route_t rt;
	apsf_pkg::apsf_fb_t    fb;
	logic [31:0]           expQ[$];
	logic [41:0]           fbExp;
	logic [7:0]            b[6];
	logic [23:0]           aTab = {3'd5, 3'd5, 3'd5, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1};
	logic [23:0]           bTab = {3'd0, 3'd1, 3'd0, 3'd2, 3'd4, 3'd3, 3'd2, 3'd1};
	int                    nFail = 0, numChecks = 0, ups = 0, dns = 0, seed = 54;
	always #25 clk_sys = ~clk_sys;
	apsf_config dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .gpPin(gp),
		.crystalPresent(xp), .route(rt), .fbDivideValue(fb), .phaseUpStep(up), .phaseDownStep(dn));
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// read expectations are queued at request time, so the monitor never races the driver
	task automatic wb(input logic w, input int ix, input logic [7:0] d, input logic [7:0] e);
		int i;
		i = 0;
		@(posedge clk_sys);
		if (!w)
			expQ.push_back({24'h00_0000, e});
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {ix[9:0], 2'b00};
		dat <= {24'h00_0000, d};
		do begin
			@(posedge clk_sys);
			i++;
		end while (!ack && i < 20);
		if (!ack) begin
			nFail++;
			printVerdict();
		end
		cyc <= 0;
		stb <= 0;
	endtask
	always @(posedge clk_sys) begin
		if (ack && !we)
			chk("read data", rdat, expQ.pop_front());
		ups += int'(up === 1'b1);
		dns += int'(dn === 1'b1);
	end
	task automatic rtChk(input int wait_n, input logic [2:0] a, input logic [2:0] p, input logic alt);
		repeat (wait_n) @(posedge clk_sys);
		chk("pll source", rt.apllSrc, a);
		chk("bypass source", rt.bypassSrc, p);
		chk("alternate in use", rt.altInUse, alt);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1;
		repeat (3) @(posedge clk_sys);
		for (int k = 0; k < 8; k++)
			wb(0, 'h102 + (k < 2 ? k : k + 2), 0, 8'h00);
		$display("test reset values done");
		foreach (b[k]) begin
			b[k] = 8'($random(seed)) | 8'(k == 0);
			wb(1, 'h106 + k, b[k], 0);
		end
		b[5] &= 8'h03;
		fbExp = {b[5][1:0], b[4], b[3], b[2], b[1], b[0]};
		foreach (b[k])
			wb(0, 'h106 + k, 0, b[k]);
		chk("divide word", fb, fbExp);
		chk("integer part", fb.intPart, fbExp[41:33]);
		wb(1, 'h10B, 8'h00, 0);
		wb(1, 'h1F0, 8'hFF, 0);
		wb(0, 'h1F0, 0, 8'h00);
		$display("test divide word done");
		// bypass off while no-bypass codes are swept, master clock from input one, switch pin two
		wb(1, 'h120, 8'h24, 0);
		wb(0, 'h120, 0, 8'h24);
		for (int c = 0; c < 8; c++) begin
			wb(1, 'h102, 8'(c), 0);
			rtChk(3, aTab[3*c +: 3], bTab[3*c +: 3], 0);
		end
		wb(1, 'h120, 8'h25, 0);
		wb(1, 'h102, 8'h56, 0);
		rtChk(3, 3'd5, 3'd1, 0);
		chk("bypass select", rt.bypassSel, 1'b1);
		gp <= 4'b0100;
		rtChk(6, 3'd3, 3'd1, 1);
		wb(1, 'h102, 8'h16, 0);
		rtChk(3, 3'd5, 3'd1, 0);
		xp <= 0;
		gp <= 4'b0000;
		wb(1, 'h120, 8'h02, 0);
		wb(1, 'h102, 8'h00, 0);
		repeat (6) @(posedge clk_sys);
		chk("doubled", rt.xtalDoubled, 1'b1);
		chk("pin direct", rt.xtalPinDirect, 1'b1);
		chk("bypass select", rt.bypassSel, 1'b0);
		$display("test routing done");
		for (int t = 0; t < 3; t++)
			wb(1, 'h103, 8'h08 & {8{~t[0]}}, 0);
		wb(1, 'h103, 8'h28, 0);
		// pin three is not selected, so its toggles must stay silent
		repeat (2) begin
			gp <= gp ^ 4'b1010;
			repeat (6) @(posedge clk_sys);
		end
		chk("up steps", ups, 3);
		chk("down steps", dns, 2);
		wb(0, 'h122, 0, 8'h01);
		wb(0, 'h103, 0, 8'h28);
		$display("test phase steps done");
		repeat (2) @(posedge clk_sys);
		printVerdict();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		nFail++;
		printVerdict();
	end
endmodule
`default_nettype wire
